// ===== shared/asc_pkg.sv
// shared constants, types and helpers for the analyzer sample clock and trigger block
`default_nettype none
package asc_pkg;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 25;
	localparam int EDGE_GAP_NS = 20;
	localparam int EDGE_GAP_CYC = (EDGE_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int DLY_MIN_NS = 0;
	localparam int DLY_MAX_NS = 1000000000;
	localparam int DLY_MAX_CYC = DLY_MAX_NS / CLK_PERIOD_NS;
	localparam int PER_BASE_NS = 100;
	localparam int PER_BASE_CYC = PER_BASE_NS / CLK_PERIOD_NS;
	localparam logic [4:0] PER_IDX_MAX = 5'h15;
	localparam logic [4:0] PER_IDX_RST = 5'h00;
	localparam logic [4:0] PER_IDX_DECADE = 5'h03;

	// ------------------------------------------------------------
	// register map (byte offsets)
	// ------------------------------------------------------------
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_STEP = 8'h04;
	localparam logic [7:0] OFF_CLK_DELAY = 8'h08;
	localparam logic [7:0] OFF_TRIG_COUNT = 8'h0C;
	localparam logic [7:0] OFF_TRIG_DELAY = 8'h10;
	localparam logic [7:0] OFF_PATTERN = 8'h14;
	localparam logic [7:0] OFF_CARE = 8'h18;
	localparam logic [7:0] OFF_STATUS = 8'h1C;
	localparam logic [7:0] OFF_PERIOD = 8'h20;

	// step command bits
	localparam int STEP_UP_BIT = 0;
	localparam int STEP_DOWN_BIT = 1;
	localparam int STEP_FAST_UP_BIT = 2;
	localparam int STEP_FAST_DOWN_BIT = 3;

	// reset values and trigger count limits
	localparam logic [11:0] CTRL_RST = 12'h000;
	localparam logic [25:0] CLK_DELAY_RST = 26'h0000000;
	localparam logic [4:0] TRIG_COUNT_RST = 5'h01;
	localparam logic [4:0] TRIG_COUNT_MIN = 5'h01;
	localparam logic [4:0] TRIG_COUNT_MAX = 5'h10;
	localparam logic [15:0] TRIG_DELAY_RST = 16'h0000;
	localparam logic [31:0] PATTERN_RST = 32'h00000000;
	localparam logic [31:0] CARE_RST = 32'h00000000;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ------------------------------------------------------------
	// modes and states
	// ------------------------------------------------------------
	typedef enum logic [1:0] {ED_RISE = 2'b00, ED_FALL = 2'b01, ED_BOTH = 2'b10} asc_edge_e;
	typedef enum logic [1:0] {QM_IGNORE = 2'b00, QM_HIGH = 2'b01, QM_LOW = 2'b10} asc_qual_e;
	typedef enum logic [1:0] {AM_IGNORE = 2'b00, AM_RISE = 2'b01, AM_FALL = 2'b10} asc_arm_e;
	typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_HUNT = 2'b01, ST_DELAY = 2'b10,
		ST_DONE = 2'b11} asc_state_e;

	typedef struct packed {
		logic stop_mode;
		logic allow_gaps;
		logic [1:0] tq_mode;
		logic [1:0] arm_mode;
		logic [1:0] cq_mode;
		logic [1:0] edge_sel;
		logic int_clk;
		logic run;
	} asc_ctrl_s;

	typedef struct packed {
		logic up;
		logic down;
		logic fast_up;
		logic fast_down;
	} asc_step_s;

	// qualifier gate shared by clock and trigger qualifiers
	function automatic logic qual_ok(input logic [1:0] mode, input logic lvl);
		qual_ok = (mode == QM_HIGH) ? lvl : (mode == QM_LOW) ? ~lvl : 1'b1;
	endfunction

endpackage
`default_nettype wire

// ===== testbench/asc_sample_trigger_monitor.sv
// port-level checks for the analyzer sample clock and trigger block
`timescale 1ns/1ps
`default_nettype none
module asc_sample_trigger_monitor
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic sample_clk_out,
	input wire logic trig_start_out,
	input wire logic trig_stop_out,
	input wire logic triggered_out
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	sequence aw_w_taken;
		ce && s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence trig_pulse;
		ce && (trig_start_out || trig_stop_out);
	endsequence
	chk_reset_idle: assert property ($rose(aresetn) |-> !triggered_out && s_axi_arready)
		else $error("outputs not idle after reset");
	chk_write_answer: assert property (aw_w_taken |-> ##[1:3] s_axi_bvalid)
		else $error("write response missing");
	chk_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
	chk_read_answer: assert property (ce && s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read data late");
	chk_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
	chk_arready_free: assert property (ce && s_axi_rvalid && s_axi_rready |=> s_axi_arready)
		else $error("read address ready wrong");
	chk_trig_single: assert property (trig_pulse |=> !trig_start_out && !trig_stop_out)
		else $error("trigger pulse too long");
	chk_trig_level: assert property (trig_pulse |-> ##[0:3] triggered_out)
		else $error("trigger level missing");
	chk_sample_single: assert property (ce && sample_clk_out |=> !sample_clk_out)
		else $error("sample clock pulse too long");
endmodule
bind asc_sample_trigger asc_sample_trigger_monitor i_mon (.*);
`default_nettype wire

// ===== testbench/asc_stim_source.sv
// stimulus source model: external sampling clock and data word
`timescale 1ns/1ps
`default_nettype none
module asc_stim_source
(
	input wire logic aclk,
	input wire logic en,
	input wire logic alt,
	input wire logic [31:0] word,
	output logic ext_clk,
	output logic [31:0] data
);
	logic [1:0] div = 2'h0;
	logic ph = 1'b0;
	initial ext_clk = 1'b0;
	initial data = 32'h0;
	// edges 100 ns apart; the clock stands low while disabled
	always @(posedge aclk)
	begin
		div <= en ? div + 2'h1 : 2'h0;
		if (!en)
			ext_clk <= 1'b0;
		else if (div == 2'h3)
			ext_clk <= ~ext_clk;
		// data moves on the falling edge so it is settled for the rising one
		if (ext_clk && div == 2'h3)
		begin
			ph <= ~ph;
			data <= (alt && ph) ? ~word : word;
		end
	end
endmodule
`default_nettype wire

// ===== testbench/testbench.sv
// self-checking bench for the analyzer sample clock and trigger block
`timescale 1ns/1ps
`default_nettype none
module testbench
	import asc_pkg::*;
;
	logic aclk = 1'b0, aresetn = 1'b0, ce = 1'b1, arm_in = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, data_in, rdat, word = 32'h0;
	logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, clk_qual_in = 1'b0;
	logic trig_qual_in = 1'b0, src_en = 1'b0, src_alt = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic ext_clk_in, sample_clk_out, trig_start_out, trig_stop_out, triggered_out;
	int err_total = 0, tests_run = 0, n_smp = 0, n_start = 0, n_stop = 0, n0, n1, i;
	logic [7:0] ra [10] = '{OFF_CTRL, OFF_STEP, OFF_CLK_DELAY, OFF_TRIG_COUNT,
		OFF_TRIG_DELAY, OFF_PATTERN, OFF_CARE, OFF_STATUS, OFF_PERIOD, 8'h24};
	logic [31:0] rv [10] = '{0, 0, 0, 1, 0, 0, 0, 0, 4, 0};
	logic [31:0] pe [5] = '{8, 20, 200, 80, 8};
	logic [3:0] st [5] = '{4'h1, 4'h1, 4'h4, 4'h2, 4'h8};
	logic [11:0] cq [8] = '{12'h013, 12'h013, 12'h023, 12'h023,
		12'h103, 12'h103, 12'h203, 12'h203};
	logic [7:0] lv = 8'b01100110;
	logic [7:0] ex = 8'hAA;
	logic [31:0] em [3] = '{32'h001, 32'h005, 32'h009};
	logic [31:0] eg [3] = '{3, 3, 6};
	always #12.5 aclk = ~aclk;
	asc_sample_trigger i_dut (.*);
	asc_stim_source i_src (.aclk, .en(src_en), .alt(src_alt), .word, .ext_clk(ext_clk_in),
		.data(data_in));
	always @(posedge aclk)
	begin
		n_smp <= n_smp + int'(sample_clk_out);
		n_start <= n_start + int'(trig_start_out);
		n_stop <= n_stop + int'(trig_stop_out);
	end
	// ----------------------------------------
	// bus and check tasks
	// ----------------------------------------
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			err_total++;
			$display("mismatch %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic tmo(input int n);
		if (n >= 600)
		begin
			err_total++;
			$display("mismatch handshake expected answer seen none");
			results();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int n;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		n = 0;
		do
		begin
			@(posedge aclk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
			n++;
		end
		while (n < 600 && s_axi_bvalid !== 1'b1);
		rsp = s_axi_bresp;
		tmo(n);
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
		int n;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		n = 0;
		do
		begin
			@(posedge aclk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
			n++;
		end
		while (n < 600 && s_axi_rvalid !== 1'b1);
		rdat = s_axi_rdata;
		rsp = s_axi_rresp;
		tmo(n);
		chk("rdata", rdat, e);
		chk("rresp", {30'h0, rsp}, {30'h0, r});
	endtask
	task automatic wtrig(input logic e);
		int n;
		for (n = 0; n < 600 && triggered_out !== 1'b1; n++)
			@(posedge aclk);
		chk("triggered", {31'h0, triggered_out}, {31'h0, e});
		if (e && n >= 600)
			results();
	endtask
	task automatic results;
		$display("checks %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	initial
	begin
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		for (i = 0; i < 10; i++)
			rchk(ra[i], rv[i], (i == 9) ? RESP_SLVERR : RESP_OKAY);
		wr(8'h02, 32'hFF);
		chk("bresp", {30'h0, rsp}, {30'h0, RESP_SLVERR});
		$display("test reset done");
		for (i = 0; i < 5; i++)
		begin
			wr(OFF_STEP, {28'h0, st[i]});
			rchk(OFF_PERIOD, pe[i], RESP_OKAY);
		end
		wr(OFF_PERIOD, 32'h99);
		rchk(OFF_PERIOD, 32'h8, RESP_OKAY);
		$display("test period done");
		n0 = n_start;
		n1 = n_stop;
		wr(OFF_CLK_DELAY, 32'h3E8);
		wr(OFF_CTRL, 32'h00B);
		wtrig(1'b1);
		wr(OFF_CTRL, 32'h80B);
		wtrig(1'b1);
		repeat (4) @(posedge aclk);
		chk("start", n_start - n0, 1);
		chk("stop", n_stop - n1, 1);
		for (i = 0; i < 8; i++)
		begin
			clk_qual_in <= lv[i];
			trig_qual_in <= lv[i];
			wr(OFF_CTRL, {20'h0, cq[i]});
			wtrig(ex[i]);
		end
		for (i = 0; i < 2; i++)
		begin
			wr(OFF_CTRL, i ? 32'h083 : 32'h043);
			wtrig(1'b0);
			ce <= 1'b0;
			arm_in <= ~arm_in;
			wtrig(1'b0);
			ce <= 1'b1;
			wtrig(1'b1);
		end
		$display("test internal done");
		wr(OFF_CLK_DELAY, 32'h0);
		wr(OFF_PATTERN, 32'hA5);
		wr(OFF_CARE, 32'hFF);
		wr(OFF_TRIG_COUNT, 32'h3);
		word <= 32'h123456A4;
		src_en <= 1'b1;
		for (i = 0; i < 3; i++)
		begin
			wr(OFF_CTRL, em[i]);
			n0 = n_smp;
			wtrig(1'b0);
			chk("samples", (n_smp - n0 + 10) / 25, eg[i]);
		end
		word <= 32'h5A5A5AA5;
		wtrig(1'b1);
		src_alt <= 1'b1;
		wr(OFF_CTRL, 32'h001);
		wtrig(1'b0);
		wr(OFF_CTRL, 32'h401);
		wtrig(1'b1);
		$display("test external done");
		results();
	end
endmodule
`default_nettype wire

// ===== verilog/asc_period_stepper.sv
// internal sampling oscillator whose period only moves in 1-2-5 or decade steps
`timescale 1ns/1ps
`default_nettype none
module asc_period_stepper
	import asc_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	input wire asc_step_s step,
	input wire logic run_osc,
	output logic [4:0] per_idx,
	output logic [25:0] per_cycles,
	output logic tick
);

	logic [4:0] idx_reg;
	logic [4:0] idx_next;
	logic [25:0] cnt_reg;
	logic [25:0] cnt_next;
	logic tick_reg;
	wire [25:0] period_cyc;

	// index = 3*decade + mantissa position; 0 is the shortest period
	function automatic logic [25:0] idx_to_cycles(input logic [4:0] idx);
		logic [31:0] mant;
		logic [31:0] pow;
		logic [4:0] dec;
		mant = 32'h00000001;
		pow = 32'h00000001;
		dec = idx / 5'h03;
		case (idx % 5'h03)
			5'h01: mant = 32'h00000002;
			5'h02: mant = 32'h00000005;
			default: mant = 32'h00000001;
		endcase
		for (int i = 0; i < 8; i++)
		begin
			if (i < dec)
				pow = pow * 32'h0000000A;
		end
		idx_to_cycles = 26'(mant * pow * 32'(PER_BASE_CYC));
	endfunction

	assign period_cyc = idx_to_cycles(idx_reg);

	// no arbitrary value path: only the four step strobes move the index
	always_comb
	begin
		idx_next = idx_reg;
		if (step.fast_up && idx_reg <= PER_IDX_MAX - PER_IDX_DECADE) // R10 R11
			idx_next = idx_reg + PER_IDX_DECADE;
		else if (step.fast_down && idx_reg >= PER_IDX_DECADE) // R10
			idx_next = idx_reg - PER_IDX_DECADE;
		else if (step.up && idx_reg < PER_IDX_MAX) // R9
			idx_next = idx_reg + 5'h01;
		else if (step.down && idx_reg != 5'h00) // R9
			idx_next = idx_reg - 5'h01;
	end

	// free-running divider, independent of any external source
	always_comb
	begin
		if (!run_osc || cnt_reg >= period_cyc - 26'h0000001) // R1
			cnt_next = 26'h0000000;
		else
			cnt_next = cnt_reg + 26'h0000001;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			idx_reg <= PER_IDX_RST;
			cnt_reg <= 26'h0000000;
			tick_reg <= 1'b0;
		end
		else if (ce)
		begin
			idx_reg <= idx_next;
			cnt_reg <= cnt_next;
			tick_reg <= run_osc && cnt_reg >= period_cyc - 26'h0000001;
		end
	end

	assign per_idx = idx_reg;
	assign per_cycles = period_cyc;
	assign tick = tick_reg;

endmodule
`default_nettype wire

// ===== verilog/asc_sample_trigger.sv
// analyzer sampling clock conditioning and trigger qualification with an AXI4-Lite register slave
//
// How it works
// R1 - sample clock is external pin or free internal oscillator, selected by software
// R2 - external clock samples on rising or falling edge as configured
// R3 - dual-edge mode samples both edges; source keeps 20 ns between edges
// R4 - edge selection and delay act only while external clock is selected
// R5 - sampling point delayed after external edge by 0 ns up to 1 s
// R6 - delayed sampling instant appears on a dedicated clock output
// R7 - clock qualifier gates sampling: high, low or ignored
// R8 - clock qualifier works for internal and external clock alike
// R9 - internal period steps up or down through 1, 2, 5 sequence
// R10 - fast step changes internal period by one decade
// R11 - internal period changes only through step commands, never by value
// R12 - trigger starts or ends the sequence depending on operating mode
// R13 - several independent trigger conditions combine into one overall trigger
// R14 - arm input edge, rising or falling, is a trigger condition
// R15 - arm set to ignore is met at first sampling edge
// R16 - sampled word compared with stored pattern flags pattern condition
// R17 - after reset every pattern bit is don't-care, so any word matches
// R18 - per-bit mask excludes masked bits from the comparison
// R19 - trigger declared only when all enabled conditions meet on one edge
// R20 - trigger qualifier input gates trigger: high, low or ignored
// R21 - qualified pattern must be seen 1 to 16 times before triggering
// R22 - without gaps occurrences must be consecutive; with gaps any occurrences count
// R23 - effective trigger delayed 0 to 65535 sampling clock periods
//
// Register access over AXI4-Lite and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
module asc_sample_trigger
	import asc_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic ext_clk_in,
	input wire logic clk_qual_in,
	input wire logic arm_in,
	input wire logic trig_qual_in,
	input wire logic [31:0] data_in,
	output logic sample_clk_out,
	output logic trig_start_out,
	output logic trig_stop_out,
	output logic triggered_out
);

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic off_mapped(input logic [7:0] addr);
		off_mapped = (addr[1:0] == 2'b00) && (addr <= OFF_PERIOD);
	endfunction

	function automatic logic [31:0] merge_strb(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		for (int i = 0; i < 4; i++)
			merge_strb[i*8 +: 8] = strb[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
	endfunction

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	asc_ctrl_s ctrl_reg;
	logic [25:0] clk_delay_reg;
	logic [4:0] trig_count_reg;
	logic [15:0] trig_delay_reg;
	logic [31:0] pattern_reg;
	logic [31:0] care_reg;
	asc_step_s step_reg;

	// ------------------------------------------------------------
	// AXI4-Lite slave
	// ------------------------------------------------------------
	logic aw_full_reg;
	logic w_full_reg;
	logic [7:0] aw_addr_reg;
	logic [31:0] w_data_reg;
	logic [3:0] w_strb_reg;
	logic bvalid_reg;
	logic [1:0] bresp_reg;
	logic rvalid_reg;
	logic [1:0] rresp_reg;
	logic [31:0] rdata_reg;
	logic [31:0] rdata_next;
	wire wr_go;
	wire rd_go;
	wire [31:0] wr_merged;
	wire [31:0] wr_old;

	assign wr_go = aw_full_reg && w_full_reg && !bvalid_reg;
	assign rd_go = s_axi_arvalid && !rvalid_reg;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_full_reg <= 1'b0;
			w_full_reg <= 1'b0;
			aw_addr_reg <= 8'h00;
			w_data_reg <= 32'h00000000;
			w_strb_reg <= 4'h0;
			bvalid_reg <= 1'b0;
			bresp_reg <= RESP_OKAY;
		end
		else if (ce)
		begin
			if (s_axi_awvalid && !aw_full_reg)
			begin
				aw_full_reg <= 1'b1;
				aw_addr_reg <= s_axi_awaddr;
			end
			if (s_axi_wvalid && !w_full_reg)
			begin
				w_full_reg <= 1'b1;
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
			end
			if (wr_go)
			begin
				aw_full_reg <= 1'b0;
				w_full_reg <= 1'b0;
				bvalid_reg <= 1'b1;
				bresp_reg <= off_mapped(aw_addr_reg) ? RESP_OKAY : RESP_SLVERR;
			end
			else if (bvalid_reg && s_axi_bready)
				bvalid_reg <= 1'b0;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rvalid_reg <= 1'b0;
			rresp_reg <= RESP_OKAY;
			rdata_reg <= 32'h00000000;
		end
		else if (ce)
		begin
			if (rd_go)
			begin
				rvalid_reg <= 1'b1;
				rresp_reg <= off_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
				rdata_reg <= rdata_next;
			end
			else if (rvalid_reg && s_axi_rready)
				rvalid_reg <= 1'b0;
		end
	end

	assign s_axi_awready = !aw_full_reg;
	assign s_axi_wready = !w_full_reg;
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_arready = !rvalid_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rresp = rresp_reg;
	assign s_axi_rdata = rdata_reg;

	// ------------------------------------------------------------
	// register writes
	// ------------------------------------------------------------
	wire wr_ctrl = wr_go && aw_addr_reg == OFF_CTRL;
	wire wr_step = wr_go && aw_addr_reg == OFF_STEP;
	wire wr_cnt = wr_go && aw_addr_reg == OFF_TRIG_COUNT;
	wire [4:0] cnt_clamped;

	assign wr_old = (aw_addr_reg == OFF_CLK_DELAY) ? {6'h00, clk_delay_reg} :
		(aw_addr_reg == OFF_TRIG_DELAY) ? {16'h0000, trig_delay_reg} :
		(aw_addr_reg == OFF_PATTERN) ? pattern_reg :
		(aw_addr_reg == OFF_CARE) ? care_reg :
		(aw_addr_reg == OFF_TRIG_COUNT) ? {27'h0000000, trig_count_reg} :
		{20'h00000, ctrl_reg};
	assign wr_merged = merge_strb(wr_old, w_data_reg, w_strb_reg);
	assign cnt_clamped = (wr_merged[31:5] != 27'h0000000 || wr_merged[4:0] > TRIG_COUNT_MAX) ?
		TRIG_COUNT_MAX : (wr_merged[4:0] < TRIG_COUNT_MIN) ? TRIG_COUNT_MIN : wr_merged[4:0];

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ctrl_reg <= CTRL_RST;
			clk_delay_reg <= CLK_DELAY_RST;
			trig_count_reg <= TRIG_COUNT_RST;
			trig_delay_reg <= TRIG_DELAY_RST;
			pattern_reg <= PATTERN_RST;
			care_reg <= CARE_RST; // R17
			step_reg <= 4'h0;
		end
		else if (ce)
		begin
			step_reg <= wr_step ? asc_step_s'({w_data_reg[STEP_UP_BIT],
				w_data_reg[STEP_DOWN_BIT], w_data_reg[STEP_FAST_UP_BIT],
				w_data_reg[STEP_FAST_DOWN_BIT]}) : 4'h0; // R11
			if (wr_ctrl)
				ctrl_reg <= asc_ctrl_s'(wr_merged[11:0]);
			if (wr_go && aw_addr_reg == OFF_CLK_DELAY)
				clk_delay_reg <= (wr_merged > 32'(DLY_MAX_CYC)) ? 26'(DLY_MAX_CYC) :
					wr_merged[25:0]; // R5
			if (wr_cnt)
				trig_count_reg <= cnt_clamped; // R21
			if (wr_go && aw_addr_reg == OFF_TRIG_DELAY)
				trig_delay_reg <= wr_merged[15:0]; // R23
			if (wr_go && aw_addr_reg == OFF_PATTERN)
				pattern_reg <= wr_merged;
			if (wr_go && aw_addr_reg == OFF_CARE)
				care_reg <= wr_merged; // R18
		end
	end

	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	logic [35:0] pin_s1_reg;
	logic [35:0] pin_s2_reg;
	logic ext_prev_reg;
	logic arm_prev_reg;
	wire [35:0] pins = {ext_clk_in, clk_qual_in, arm_in, trig_qual_in, data_in};
	wire ext_s = pin_s2_reg[35];
	wire cq_s = pin_s2_reg[34];
	wire arm_s = pin_s2_reg[33];
	wire tq_s = pin_s2_reg[32];
	wire [31:0] data_s = pin_s2_reg[31:0];

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			pin_s1_reg <= 36'h000000000;
			pin_s2_reg <= 36'h000000000;
			ext_prev_reg <= 1'b0;
			arm_prev_reg <= 1'b0;
		end
		else if (ce)
		begin
			pin_s1_reg <= pins;
			pin_s2_reg <= pin_s1_reg;
			ext_prev_reg <= ext_s;
			arm_prev_reg <= arm_s;
		end
	end

	// ------------------------------------------------------------
	// sampling clock
	// ------------------------------------------------------------
	logic [25:0] dly_cnt_reg;
	logic dly_busy_reg;
	logic sclk_reg;
	wire int_tick;
	wire [4:0] per_idx;
	wire [25:0] per_cycles;
	wire ext_rise = ext_s && !ext_prev_reg;
	wire ext_fall = !ext_s && ext_prev_reg;
	wire ext_edge;
	wire dly_fire;
	wire raw_tick;
	wire qtick;

	// edges closer than one clock period can both be lost by the synchroniser
	assign ext_edge = (ctrl_reg.edge_sel == ED_BOTH) ? (ext_rise || ext_fall) : // R3
		(ctrl_reg.edge_sel == ED_FALL) ? ext_fall : ext_rise; // R2
	// an edge arriving while a delay is pending is dropped, not queued
	assign dly_fire = dly_busy_reg && dly_cnt_reg == 26'h0000001;
	assign raw_tick = ctrl_reg.int_clk ? int_tick : // R1 R4
		(clk_delay_reg == 26'h0000000) ? ext_edge : dly_fire; // R5
	assign qtick = raw_tick && qual_ok(ctrl_reg.cq_mode, cq_s); // R7 R8

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			dly_cnt_reg <= 26'h0000000;
			dly_busy_reg <= 1'b0;
			sclk_reg <= 1'b0;
		end
		else if (ce)
		begin
			sclk_reg <= qtick; // R6
			if (ctrl_reg.int_clk || dly_fire)
				dly_busy_reg <= 1'b0;
			else if (ext_edge && !dly_busy_reg && clk_delay_reg != 26'h0000000)
			begin
				dly_busy_reg <= 1'b1;
				dly_cnt_reg <= clk_delay_reg; // R5
			end
			else if (dly_busy_reg)
				dly_cnt_reg <= dly_cnt_reg - 26'h0000001;
		end
	end

	asc_period_stepper u_stepper (
		.aclk(aclk),
		.aresetn(aresetn),
		.ce(ce),
		.step(step_reg),
		.run_osc(ctrl_reg.int_clk),
		.per_idx(per_idx),
		.per_cycles(per_cycles),
		.tick(int_tick)
	);

	// ------------------------------------------------------------
	// trigger sequencer
	// ------------------------------------------------------------
	asc_state_e state_reg;
	asc_state_e state_next;
	logic arm_seen_reg;
	logic [15:0] tdly_reg;
	logic start_reg;
	logic stop_reg;
	logic done_reg;
	wire run_wr = wr_ctrl && wr_merged[0];
	wire arm_edge;
	wire arm_ok;
	wire cond_ok;
	wire reached;
	wire fire;
	wire [4:0] occ_count;

	assign arm_edge = (ctrl_reg.arm_mode == AM_RISE) ? (arm_s && !arm_prev_reg) : // R14
		(ctrl_reg.arm_mode == AM_FALL) ? (!arm_s && arm_prev_reg) : 1'b0;
	// ignore mode is met by whichever qualified sample comes first
	assign arm_ok = (ctrl_reg.arm_mode == AM_IGNORE) || arm_seen_reg || arm_edge; // R15
	assign cond_ok = arm_ok && qual_ok(ctrl_reg.tq_mode, tq_s); // R13 R20
	assign fire = (state_reg == ST_DELAY && qtick && tdly_reg == 16'h0001) ||
		(state_reg == ST_HUNT && reached && trig_delay_reg == 16'h0000); // R23

	asc_word_counter u_counter (
		.aclk(aclk),
		.aresetn(aresetn),
		.ce(ce),
		.clear(run_wr),
		.hunt(state_reg == ST_HUNT && !reached),
		.qtick(qtick),
		.word(data_s),
		.pattern(pattern_reg),
		.care(care_reg),
		.cond_ok(cond_ok),
		.allow_gaps(ctrl_reg.allow_gaps),
		.count_req(trig_count_reg),
		.count(occ_count),
		.reached(reached)
	);

	always_comb
	begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE: state_next = ST_IDLE;
			ST_HUNT:
			begin
				if (reached)
					state_next = fire ? ST_DONE : ST_DELAY;
			end
			ST_DELAY:
			begin
				if (fire)
					state_next = ST_DONE;
			end
			ST_DONE: state_next = ST_DONE;
			default: state_next = ST_IDLE;
		endcase
		if (run_wr)
			state_next = ST_HUNT;
		else if (wr_ctrl)
			state_next = ST_IDLE;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state_reg <= ST_IDLE;
			arm_seen_reg <= 1'b0;
			tdly_reg <= 16'h0000;
			start_reg <= 1'b0;
			stop_reg <= 1'b0;
			done_reg <= 1'b0;
		end
		else if (ce)
		begin
			state_reg <= state_next;
			if (run_wr)
				arm_seen_reg <= 1'b0;
			else if (state_reg == ST_HUNT && arm_edge)
				arm_seen_reg <= 1'b1; // R14
			if (state_reg == ST_HUNT && reached)
				tdly_reg <= trig_delay_reg;
			else if (state_reg == ST_DELAY && qtick)
				tdly_reg <= tdly_reg - 16'h0001; // R23
			start_reg <= fire && !ctrl_reg.stop_mode; // R12
			stop_reg <= fire && ctrl_reg.stop_mode; // R12
			done_reg <= state_next == ST_DONE;
		end
	end

	// ------------------------------------------------------------
	// read mux and outputs
	// ------------------------------------------------------------
	always_comb
	begin
		case (s_axi_araddr)
			OFF_CTRL: rdata_next = {20'h00000, ctrl_reg};
			OFF_STEP: rdata_next = {27'h0000000, per_idx};
			OFF_CLK_DELAY: rdata_next = {6'h00, clk_delay_reg};
			OFF_TRIG_COUNT: rdata_next = {27'h0000000, trig_count_reg};
			OFF_TRIG_DELAY: rdata_next = {16'h0000, trig_delay_reg};
			OFF_PATTERN: rdata_next = pattern_reg;
			OFF_CARE: rdata_next = care_reg;
			OFF_STATUS: rdata_next = {tdly_reg, 3'h0, occ_count, 5'h00, arm_seen_reg,
				state_reg};
			OFF_PERIOD: rdata_next = {6'h00, per_cycles};
			default: rdata_next = 32'h00000000;
		endcase
	end

	assign sample_clk_out = sclk_reg;
	assign trig_start_out = start_reg;
	assign trig_stop_out = stop_reg;
	assign triggered_out = done_reg;

endmodule
`default_nettype wire

// ===== verilog/asc_word_counter.sv
// trigger word match and occurrence counting with optional gaps
`timescale 1ns/1ps
`default_nettype none
module asc_word_counter
	import asc_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	input wire logic clear,
	input wire logic hunt,
	input wire logic qtick,
	input wire logic [31:0] word,
	input wire logic [31:0] pattern,
	input wire logic [31:0] care,
	input wire logic cond_ok,
	input wire logic allow_gaps,
	input wire logic [4:0] count_req,
	output logic [4:0] count,
	output logic reached
);

	logic [4:0] cnt_reg;
	logic [4:0] cnt_next;
	logic reached_reg;
	wire match;
	wire hit;
	wire [4:0] cnt_inc;

	// care bit 0 removes the bit from the comparison; all zero matches anything
	assign match = ((word ^ pattern) & care) == 32'h00000000; // R16 R18
	// every enabled condition on the same qualified edge
	assign hit = qtick && hunt && match && cond_ok; // R19
	assign cnt_inc = cnt_reg + 5'h01;

	always_comb
	begin
		cnt_next = cnt_reg;
		if (clear)
			cnt_next = 5'h00;
		else if (hit)
			cnt_next = (cnt_inc >= count_req) ? 5'h00 : cnt_inc; // R21
		else if (qtick && hunt && !allow_gaps)
			cnt_next = 5'h00; // R22
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			cnt_reg <= 5'h00;
			reached_reg <= 1'b0;
		end
		else if (ce)
		begin
			cnt_reg <= cnt_next;
			reached_reg <= hit && !clear && cnt_inc >= count_req; // R21
		end
	end

	assign count = cnt_reg;
	assign reached = reached_reg;

endmodule
`default_nettype wire
